/* core/modbus_map_defs.svh */
`ifndef MODBUS_MAP_DEFS_SVH
`define MODBUS_MAP_DEFS_SVH

// ****************************************
// Function codes and exception codes
// ****************************************
`define FC_RD_HOLD 8'h03
`define FC_RD_INPUT 8'h04
`define FC_WR_SINGLE 8'h06
`define FC_WR_MULTI 8'h10
`define FC_RD_WR 8'h17
`define EXC_NONE 8'h00
`define EXC_ILL_FUNC 8'h01
`define EXC_ILL_ADDR 8'h02
`define EXC_ILL_VALUE 8'h03

// ****************************************
// Special, diagnostic and parameter channel words
// ****************************************
`define ADDR_CONN_TIMEOUT 16'h0500
`define ADDR_WDOG_TIMEOUT 16'h07d0
`define ADDR_FAULT_MODE 16'h07d2
`define ADDR_FAIL_REASON 16'h07d4
`define ADDR_COMMAND 16'h07d6
`define ADDR_PCHAN_FIRST 16'h1784
`define ADDR_PCHAN_LAST 16'h181d
`define PCHAN_WORDS 154
`define PCHAN_BLOCK 8'h0a
`define PCHAN_USED 8'h04
`define ADDR_STATUS 16'h1f3c
`define ADDR_LB_DIAG 16'h1f3d
`define ADDR_DIAG_PAR1 16'h1f3e
`define ADDR_DIAG_PAR2 16'h1f3f

// ****************************************
// Process data, dynamic and static tables
// ****************************************
`define ADDR_LOCAL_DI 16'h1f40
`define BUS_IN_WORDS 16'h0004
`define BUS_OUT_WORDS 16'h0004
`define ADDR_ST_IN_LAST 16'h017f
`define ADDR_ST_OUT_FIRST 16'h0180
`define ADDR_ST_OUT_LAST 16'h02ff
`define IMG_WORDS 384
`define IMG_HALF 9'h0c0

// ****************************************
// Field positions, values and reset values
// ****************************************
`define LB_USER_BIT 0
`define LB_PERIPH_BIT 1
`define LB_SEGMENT_BIT 2
`define LB_MASTER_BIT 3
`define TIMEOUT_MIN 16'h00c8
`define TIMEOUT_MAX 16'hfde8
`define FAULT_MODE_MAX 16'h0002
`define CMD_NETFAIL_ACK 16'h0002
`define RST_CONN_TIMEOUT 16'h0000
`define RST_WDOG_TIMEOUT 16'h01f4
`define RST_FAULT_MODE 16'h0001
`define ANALOG_DEFAULT 16'h0000

`endif

/* core/modbus_map_pkg.sv */
package modbus_map_pkg;

   // One word access from the Modbus engine
   typedef struct packed {
      logic [7:0] fc;
      logic [15:0] addr;
      logic [15:0] wdata;
      logic write;
   } mb_req_s;

   // Answer to one word access
   typedef struct packed {
      logic [15:0] data;
      logic [7:0] exc;
   } mb_rsp_s;

   // State and events from the local bus master
   typedef struct packed {
      logic selftestDone;
      logic configured;
      logic cycling;
      logic searchStart;
      logic [3:0] errEvent;
      logic [15:0] errParam1;
      logic [15:0] errParam2;
   } lb_diag_s;

   // Fault response modes
   typedef enum logic [1:0] {FAULT_ZERO, FAULT_RESET, FAULT_HOLD} fault_mode_e;

endpackage

/* core/modbus_register_map.sv */
// What this block does
// R1 - Accept only function codes 3,4,6,16,23
// R2 - Five read/write special words at fixed addresses
// R3 - Parameter channel words at 6020 to 6173
// R4 - Four read-only diagnostic words 7996-7999
// R5 - Local inputs at 8000, then bus inputs
// R6 - Local outputs then bus outputs, read/write
// R7 - Static table: inputs, analog inputs, outputs, analog
// R8 - Status bits 2 to 15 reserved, zero
// R9 - Status bit 0 set when error free
// R10 - Status bit 1 follows link-loss fault
// R11 - Diag bits 0-3: user, peripheral, segment, master
// R12 - Diag bits 4-7: search, cycling, configured, selftest
// R13 - Parameter word rewritten on error, else zero
// R14 - Selftest flag set after master selftest
// R15 - Configured flag needs selftest flag set
// R16 - Cycling flag needs configured and selftest
// R17 - Operating flags leave parameter word alone
// R18 - Error flags stay until acknowledged
// R19 - Search flag set, outputs to fault state
// R20 - Cause found: clear search, set error flag
// R21 - Master and segment errors stop local bus
// R22 - Peripheral and user errors keep bus running
// R23 - Fault modes: zero, reset defaults, hold last
// R24 - Fail reason reads zero without link loss
// R25 - Bad code or address gets exception
`include "modbus_map_defs.svh"

module modbus_register_map (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Modbus word access
   input wire logic reqValid,
   input wire modbus_map_pkg::mb_req_s req,
   output logic rspValid,
   output modbus_map_pkg::mb_rsp_s rsp,
   // Local bus master state and events
   input wire modbus_map_pkg::lb_diag_s lbDiag,
   input wire logic errAck,
   output logic localBusStop,
   // Process image exchange with the local bus master
   input wire logic inImgWrValid,
   input wire logic [8:0] inImgWrIdx,
   input wire logic [15:0] inImgWrData,
   input wire logic [8:0] outImgRdIdx,
   output logic [15:0] outImgRdData,
   // Link-loss fault from the watchdog
   input wire logic netFail,
   input wire logic [15:0] netFailCode,
   output logic netFailAck,
   // Local digital pins
   input wire logic [7:0] localDiPins,
   output logic [3:0] localDoPins
);

   // ****************************************
   // Storage
   // ****************************************
   logic [15:0] inImg [`IMG_WORDS];
   logic [15:0] outImg [`IMG_WORDS];
   logic [15:0] pchanMem [`PCHAN_WORDS];
   logic [15:0] connTimeout_r, wdogTimeout_r, faultMode_r, failReason_r, command_r;
   logic [15:0] localDo_r, diagPar1_r, diagPar2_r;
   logic [7:0] diSync1_r, diSync2_r;
   logic readyFlag_r, activeFlag_r, runFlag_r, detect_r, netFailQ_r;
   logic [3:0] errFlags_r;

   // Parameter channel offset is reserved inside its block of ten
   function automatic logic pchanReserved(input logic [15:0] a);
      logic [15:0] off;
      off = a - `ADDR_PCHAN_FIRST;
      return (off[7:0] % `PCHAN_BLOCK) >= `PCHAN_USED;
   endfunction

   // Timeout word value outside the allowed range
   function automatic logic timeoutBad(input logic [15:0] v);
      return (v != 16'h0000) && ((v < `TIMEOUT_MIN) || (v > `TIMEOUT_MAX));
   endfunction

   // ****************************************
   // Address decode
   // ****************************************
   wire fcOk = (req.fc == `FC_RD_HOLD) || (req.fc == `FC_RD_INPUT) ||
      (req.fc == `FC_WR_SINGLE) || (req.fc == `FC_WR_MULTI) || (req.fc == `FC_RD_WR); // R1
   wire fcRead = (req.fc == `FC_RD_HOLD) || (req.fc == `FC_RD_INPUT) || (req.fc == `FC_RD_WR);
   wire fcWrite = (req.fc == `FC_WR_SINGLE) || (req.fc == `FC_WR_MULTI) ||
      (req.fc == `FC_RD_WR);
   wire isConn = req.addr == `ADDR_CONN_TIMEOUT;
   wire isWdog = req.addr == `ADDR_WDOG_TIMEOUT;
   wire isMode = req.addr == `ADDR_FAULT_MODE;
   wire isFail = req.addr == `ADDR_FAIL_REASON;
   wire isCmd = req.addr == `ADDR_COMMAND;
   wire isSpecial = isConn || isWdog || isMode || isFail || isCmd; // R2
   wire isPchan = (req.addr >= `ADDR_PCHAN_FIRST) && (req.addr <= `ADDR_PCHAN_LAST) &&
      !pchanReserved(req.addr); // R3
   wire isDiag = (req.addr >= `ADDR_STATUS) && (req.addr <= `ADDR_DIAG_PAR2); // R4
   wire isLocDi = req.addr == `ADDR_LOCAL_DI; // R5
   wire isBusIn = (req.addr > `ADDR_LOCAL_DI) &&
      (req.addr <= `ADDR_LOCAL_DI + `BUS_IN_WORDS); // R5
   wire [15:0] locDoAddr = `ADDR_LOCAL_DI + `BUS_IN_WORDS + 16'h0001;
   wire isLocDo = req.addr == locDoAddr; // R6
   wire isBusOut = (req.addr > locDoAddr) && (req.addr <= locDoAddr + `BUS_OUT_WORDS); // R6
   wire isStIn = req.addr <= `ADDR_ST_IN_LAST; // R7
   wire isStOut = (req.addr >= `ADDR_ST_OUT_FIRST) && (req.addr <= `ADDR_ST_OUT_LAST); // R7
   wire roAddr = isDiag || isLocDi || isBusIn || isStIn;
   wire rwAddr = isSpecial || isPchan || isLocDo || isBusOut || isStOut;

   // Image and channel indices
   wire [15:0] busInOff = req.addr - `ADDR_LOCAL_DI - 16'h0001;
   wire [15:0] busOutOff = req.addr - locDoAddr - 16'h0001;
   wire [15:0] stOutOff = req.addr - `ADDR_ST_OUT_FIRST;
   wire [15:0] pchanOff = req.addr - `ADDR_PCHAN_FIRST;
   wire [8:0] inIdx = isBusIn ? busInOff[8:0] : req.addr[8:0];
   wire [8:0] outIdx = isBusOut ? busOutOff[8:0] : stOutOff[8:0];
   wire [7:0] pchanIdx = pchanOff[7:0];

   // ****************************************
   // Request check and exception choice
   // ****************************************
   wire valueBad = ((isConn || isWdog) && timeoutBad(req.wdata)) ||
      (isMode && (req.wdata > `FAULT_MODE_MAX));
   wire [7:0] excCode =
      (!fcOk || (req.write && !fcWrite) || (!req.write && !fcRead)) ? `EXC_ILL_FUNC :
      (req.write ? !rwAddr : !(roAddr || rwAddr)) ? `EXC_ILL_ADDR :
      (req.write && valueBad) ? `EXC_ILL_VALUE : `EXC_NONE; // R25
   wire doWrite = reqValid && req.write && (excCode == `EXC_NONE);

   // ****************************************
   // Diagnostic word contents
   // ****************************************
   wire anyErr = |errFlags_r;
   wire faultActive = detect_r || netFail || localBusStop; // R19
   wire [15:0] statusWord = {14'h0000, netFail, !(anyErr || detect_r || netFail)}; // R8 R9 R10
   wire [15:0] lbDiagWord = {8'h00, readyFlag_r, activeFlag_r, runFlag_r, detect_r,
      errFlags_r}; // R11 R12
   wire [15:0] diagPar1 = anyErr ? diagPar1_r : 16'h0000; // R13
   wire [15:0] diagPar2 = anyErr ? diagPar2_r : 16'h0000; // R13
   wire [15:0] failRead = netFail ? failReason_r : 16'h0000; // R24
   assign localBusStop = errFlags_r[`LB_SEGMENT_BIT] || errFlags_r[`LB_MASTER_BIT]; // R21 R22

   // Read data selection
   wire [15:0] rdData =
      isConn ? connTimeout_r : isWdog ? wdogTimeout_r : isMode ? faultMode_r :
      isFail ? failRead : isCmd ? command_r : isPchan ? pchanMem[pchanIdx] :
      (req.addr == `ADDR_STATUS) ? statusWord : (req.addr == `ADDR_LB_DIAG) ? lbDiagWord :
      (req.addr == `ADDR_DIAG_PAR1) ? diagPar1 : (req.addr == `ADDR_DIAG_PAR2) ? diagPar2 :
      isLocDi ? {8'h00, diSync2_r} : (isBusIn || isStIn) ? inImg[inIdx] :
      isLocDo ? localDo_r : (isBusOut || isStOut) ? outImg[outIdx] : 16'h0000;

   // Output value under the fault response
   wire [15:0] outImgSel = outImg[outImgRdIdx];
   wire [15:0] outFaultVal =
      (faultMode_r[1:0] == modbus_map_pkg::FAULT_HOLD) ? outImgSel :
      (faultMode_r[1:0] == modbus_map_pkg::FAULT_RESET && outImgRdIdx >= `IMG_HALF) ?
      `ANALOG_DEFAULT : 16'h0000; // R23
   wire [15:0] outImgNext = faultActive ? outFaultVal : outImgSel; // R19
   wire holdOut = faultActive && (faultMode_r[1:0] == modbus_map_pkg::FAULT_HOLD);
   wire [3:0] localDoNext = (faultActive && !holdOut) ? 4'h0 : localDo_r[3:0]; // R23

   // ****************************************
   // Answer register
   // ****************************************
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rspValid <= 1'b0;
         rsp <= '0;
      end else begin
         rspValid <= reqValid;
         rsp.exc <= excCode; // R25
         rsp.data <= (excCode == `EXC_NONE && !req.write) ? rdData : 16'h0000;
      end
   end

   // ****************************************
   // Special words and local outputs
   // ****************************************
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         connTimeout_r <= `RST_CONN_TIMEOUT;
         wdogTimeout_r <= `RST_WDOG_TIMEOUT;
         faultMode_r <= `RST_FAULT_MODE;
         command_r <= 16'h0000;
         localDo_r <= 16'h0000;
         netFailAck <= 1'b0;
      end else begin
         if (doWrite && isConn) connTimeout_r <= req.wdata; // R2
         if (doWrite && isWdog) wdogTimeout_r <= req.wdata; // R2
         if (doWrite && isMode) faultMode_r <= req.wdata; // R2
         if (doWrite && isCmd) command_r <= req.wdata; // R2
         if (doWrite && isLocDo && !holdOut) localDo_r <= req.wdata; // R6
         netFailAck <= doWrite && isCmd && (req.wdata == `CMD_NETFAIL_ACK);
      end
   end

   // Fail reason caught when the link-loss fault rises
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         failReason_r <= 16'h0000;
         netFailQ_r <= 1'b0;
      end else begin
         netFailQ_r <= netFail;
         if (netFail && !netFailQ_r) failReason_r <= netFailCode;
         else if (doWrite && isFail) failReason_r <= req.wdata; // R2
      end
   end

   // ****************************************
   // Memories: images and parameter channel
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (inImgWrValid) inImg[inImgWrIdx] <= inImgWrData;
      if (doWrite && (isBusOut || isStOut) && !holdOut) outImg[outIdx] <= req.wdata; // R6 R7
      if (doWrite && isPchan) pchanMem[pchanIdx] <= req.wdata; // R3
   end

   // Pin sync and registered image and pin outputs
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         diSync1_r <= 8'h00;
         diSync2_r <= 8'h00;
         outImgRdData <= 16'h0000;
         localDoPins <= 4'h0;
      end else begin
         diSync1_r <= localDiPins;
         diSync2_r <= diSync1_r;
         outImgRdData <= outImgNext;
         localDoPins <= localDoNext;
      end
   end

   // ****************************************
   // Local bus operating and error flags
   // ****************************************
   wire errFound = |lbDiag.errEvent;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         readyFlag_r <= 1'b0;
         activeFlag_r <= 1'b0;
         runFlag_r <= 1'b0;
      end else begin
         readyFlag_r <= lbDiag.selftestDone; // R14
         activeFlag_r <= lbDiag.selftestDone && lbDiag.configured; // R15
         runFlag_r <= lbDiag.selftestDone && lbDiag.configured && lbDiag.cycling; // R16
      end
   end

   // Sticky error flags, a new event beats the acknowledge
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         errFlags_r <= 4'h0;
         detect_r <= 1'b0;
      end else begin
         errFlags_r <= (errAck ? 4'h0 : errFlags_r) | lbDiag.errEvent; // R18 R20
         if (lbDiag.searchStart) detect_r <= 1'b1; // R19
         else if (errFound) detect_r <= 1'b0; // R20
      end
   end

   // Parameter words reloaded only by error events
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         diagPar1_r <= 16'h0000;
         diagPar2_r <= 16'h0000;
      end else if (errFound) begin
         diagPar1_r <= lbDiag.errParam1; // R13 R17 R21 R22
         diagPar2_r <= lbDiag.errParam2; // R13
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   sequence sBadFc;
      reqValid && !fcOk;
   endsequence

   sequence sWriteDiag;
      reqValid && req.write && fcWrite && isDiag;
   endsequence

   sequence sBadTimeout;
      reqValid && req.write && fcWrite && (isConn || isWdog) && timeoutBad(req.wdata);
   endsequence

   sequence sMode0Fault;
      faultActive && (faultMode_r == 16'h0000);
   endsequence

   AST_BAD_FC: assert property (@(posedge core_clk) disable iff (!rst_n) // R1
      sBadFc |=> rspValid && rsp.exc == `EXC_ILL_FUNC)
      else $error("unsupported function code not refused");
   AST_RO_DIAG: assert property (@(posedge core_clk) disable iff (!rst_n) // R4
      sWriteDiag |=> rspValid && rsp.exc == `EXC_ILL_ADDR)
      else $error("write to diagnostic word not refused");
   AST_TIMEOUT_RANGE: assert property (@(posedge core_clk) disable iff (!rst_n) // R2
      sBadTimeout |=> rsp.exc == `EXC_ILL_VALUE && $stable(connTimeout_r) && $stable(wdogTimeout_r))
      else $error("bad timeout value accepted");
   AST_STATUS_OK: assert property (@(posedge core_clk) disable iff (!rst_n) // R9
      (errFlags_r == 4'h0 && !detect_r && !netFail) |-> statusWord == 16'h0001)
      else $error("status word not error free");
   AST_STATUS_NETFAIL: assert property (@(posedge core_clk) disable iff (!rst_n) // R10
      netFail |-> statusWord[1] && !statusWord[0] && statusWord[15:2] == 14'h0000)
      else $error("link loss not shown in status word");
   AST_STICKY: assert property (@(posedge core_clk) disable iff (!rst_n) // R18
      (errFlags_r != 4'h0 && !errAck) |=> (errFlags_r & $past(errFlags_r)) == $past(errFlags_r))
      else $error("error flag dropped without acknowledge");
   AST_PARAM_ZERO: assert property (@(posedge core_clk) disable iff (!rst_n) // R13
      errFlags_r == 4'h0 |-> diagPar1 == 16'h0000 && diagPar2 == 16'h0000)
      else $error("parameter word not zero without error");
   AST_FLAG_ORDER: assert property (@(posedge core_clk) disable iff (!rst_n) // R15
      (runFlag_r |-> activeFlag_r) and (activeFlag_r |-> readyFlag_r))
      else $error("operating flags out of order");
   AST_SEARCH_END: assert property (@(posedge core_clk) disable iff (!rst_n) // R20
      (lbDiag.errEvent != 4'h0 && !lbDiag.searchStart) |=> !detect_r && errFlags_r != 4'h0)
      else $error("search flag not cleared on found cause");
   AST_SHUTDOWN: assert property (@(posedge core_clk) disable iff (!rst_n) // R21
      lbDiag.errEvent[`LB_MASTER_BIT] |=> localBusStop [*1] ##0 faultActive)
      else $error("master error did not stop local bus");
   AST_FAULT_ZERO: assert property (@(posedge core_clk) disable iff (!rst_n) // R23
      sMode0Fault |=> outImgRdData == 16'h0000 && localDoPins == 4'h0)
      else $error("outputs not zero in fault mode 0");
   AST_FAIL_ZERO: assert property (@(posedge core_clk) disable iff (!rst_n) // R24
      (reqValid && !req.write && fcRead && isFail && !netFail) |=> rsp.data == 16'h0000)
      else $error("fail reason not zero without link loss");

endmodule

/* verification/lb_master_model.sv */
module lb_master_model (
   // Clock
   input wire logic core_clk,
   // Master state and events
   output modbus_map_pkg::lb_diag_s lbDiag,
   output logic errAck,
   // Input image and local pins
   output logic inImgWrValid,
   output logic [8:0] inImgWrIdx,
   output logic [15:0] inImgWrData,
   output logic [7:0] localDiPins,
   // Link-loss fault source
   output logic netFail,
   output logic [15:0] netFailCode
);
   timeunit 1ns;
   timeprecision 1ps;

   // ****************************************
   // Idle levels at time zero
   // ****************************************
   initial begin
      lbDiag = '0;
      errAck = 1'b0;
      inImgWrValid = 1'b0;
      inImgWrIdx = 9'h000;
      inImgWrData = 16'h0000;
      localDiPins = 8'h00;
      netFail = 1'b0;
      netFailCode = 16'h0000;
   end

   // Move off the sampling edge
   task automatic step();
      @(posedge core_clk);
      #1;
   endtask

   // Operating levels of the master
   task automatic set_state(input logic st, input logic cf, input logic cy);
      step();
      lbDiag.selftestDone = st;
      lbDiag.configured = cf;
      lbDiag.cycling = cy;
   endtask

   // Search start, located error or acknowledge, one cycle each
   task automatic pulse(input logic srch, input logic [3:0] ev, input logic ack,
         input logic [15:0] p1);
      step();
      lbDiag.searchStart = srch;
      lbDiag.errEvent = ev;
      lbDiag.errParam1 = p1;
      lbDiag.errParam2 = ~p1;
      errAck = ack;
      step();
      lbDiag.searchStart = 1'b0;
      lbDiag.errEvent = 4'h0;
      errAck = 1'b0;
   endtask

   // One input image word
   task automatic img_write(input logic [8:0] idx, input logic [15:0] d);
      step();
      inImgWrValid = 1'b1;
      inImgWrIdx = idx;
      inImgWrData = d;
      step();
      inImgWrValid = 1'b0;
   endtask

   // Local input pin levels
   task automatic set_pins(input logic [7:0] p);
      step();
      localDiPins = p;
   endtask

   // Link-loss level and reason code
   task automatic set_net(input logic f, input logic [15:0] code);
      step();
      netFail = f;
      netFailCode = code;
   endtask
endmodule

/* verification/modbus_register_map_diagnostics_test.sv */
`include "modbus_map_defs.svh"

module modbus_register_map_diagnostics_test;
   timeunit 1ns;
   timeprecision 1ps;

   // ****************************************
   // Signals and tables
   // ****************************************
   logic core_clk, rst_n, reqValid, rspValid, errAck, localBusStop, inImgWrValid;
   logic netFail, netFailAck, ackSeen;
   modbus_map_pkg::mb_req_s req;
   modbus_map_pkg::mb_rsp_s rsp;
   modbus_map_pkg::lb_diag_s lbDiag;
   logic [8:0] inImgWrIdx, outImgRdIdx;
   logic [15:0] inImgWrData, outImgRdData, netFailCode, dExp, aExp;
   logic [7:0] localDiPins;
   logic [3:0] localDoPins;
   int fails, testsRun;
   localparam logic [15:0] SP_ADDR [4] = '{16'h0500, 16'h07d0, 16'h07d2, 16'h07d6};
   localparam logic [15:0] SP_VAL [4] = '{16'h00c8, 16'hfde8, 16'h0002, 16'h0000};
   localparam logic [7:0] FCS [5] = '{8'h03, 8'h04, 8'h06, 8'h10, 8'h17};
   localparam logic [15:0] MODES [4] = '{16'h0000, 16'h0001, 16'h0002, 16'h0001};

   modbus_register_map i_dut (.core_clk(core_clk), .rst_n(rst_n), .reqValid(reqValid),
      .req(req), .rspValid(rspValid), .rsp(rsp), .lbDiag(lbDiag), .errAck(errAck),
      .localBusStop(localBusStop), .inImgWrValid(inImgWrValid), .inImgWrIdx(inImgWrIdx),
      .inImgWrData(inImgWrData), .outImgRdIdx(outImgRdIdx), .outImgRdData(outImgRdData),
      .netFail(netFail), .netFailCode(netFailCode), .netFailAck(netFailAck),
      .localDiPins(localDiPins), .localDoPins(localDoPins));

   lb_master_model i_lbm (.core_clk(core_clk), .lbDiag(lbDiag), .errAck(errAck),
      .inImgWrValid(inImgWrValid), .inImgWrIdx(inImgWrIdx), .inImgWrData(inImgWrData),
      .localDiPins(localDiPins), .netFail(netFail), .netFailCode(netFailCode));

   // ****************************************
   // Clock, watchdog and shared tasks
   // ****************************************
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   // Hang guard, far beyond the expected run
   initial begin
      #400000;
      fails++;
      stop_test();
   end

   // Compare one value
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      testsRun++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One word access, answer checked one cycle later
   task automatic access(input logic [7:0] fc, input logic [15:0] addr, input logic wr,
         input logic [15:0] wd, input logic [15:0] expData, input logic [7:0] expExc);
      @(posedge core_clk);
      #1;
      reqValid = 1'b1;
      req = '{fc: fc, addr: addr, wdata: wd, write: wr};
      @(posedge core_clk);
      #1;
      reqValid = 1'b0;
      ackSeen = netFailAck;
      check({15'h0000, rspValid}, 16'h0001);
      check(rsp.data, expData);
      check({8'h00, rsp.exc}, {8'h00, expExc});
   endtask

   task automatic rd(input logic [15:0] addr, input logic [15:0] exp);
      access(`FC_RD_HOLD, addr, 1'b0, 16'h0000, exp, `EXC_NONE);
   endtask

   task automatic wr(input logic [15:0] addr, input logic [15:0] d, input logic [7:0] exc);
      access(`FC_WR_SINGLE, addr, 1'b1, d, 16'h0000, exc);
   endtask

   // Output image word, one cycle latency
   task automatic img(input logic [8:0] idx, input logic [15:0] exp);
      @(posedge core_clk);
      #1;
      outImgRdIdx = idx;
      @(posedge core_clk);
      #1;
      check(outImgRdData, exp);
   endtask

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", testsRun, fails);
      if (fails == 0 && testsRun > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // ****************************************
   // Test sequence
   // ****************************************
   initial begin
      rst_n = 1'b0;
      reqValid = 1'b0;
      req = '0;
      outImgRdIdx = 9'h000;
      ackSeen = 1'b0;
      fails = 0;
      testsRun = 0;
      repeat (2) @(posedge core_clk);
      #1;
      rst_n = 1'b1;
      rd(`ADDR_CONN_TIMEOUT, `RST_CONN_TIMEOUT);
      rd(`ADDR_WDOG_TIMEOUT, `RST_WDOG_TIMEOUT);
      rd(`ADDR_FAULT_MODE, `RST_FAULT_MODE);
      rd(`ADDR_STATUS, 16'h0001);
      rd(`ADDR_LB_DIAG, 16'h0000);
      $display("reset values test done");
      for (int i = 0; i < 4; i++) begin
         wr(SP_ADDR[i], SP_VAL[i], `EXC_NONE);
         rd(SP_ADDR[i], SP_VAL[i]);
      end
      wr(`ADDR_FAIL_REASON, 16'h1234, `EXC_NONE);
      rd(`ADDR_FAIL_REASON, 16'h0000);
      wr(`ADDR_CONN_TIMEOUT, 16'h00c7, `EXC_ILL_VALUE);
      wr(`ADDR_WDOG_TIMEOUT, 16'hfde9, `EXC_ILL_VALUE);
      wr(`ADDR_FAULT_MODE, 16'h0003, `EXC_ILL_VALUE);
      rd(`ADDR_FAULT_MODE, 16'h0002);
      for (int i = 0; i < 5; i++) begin
         access(FCS[i], 16'h0500, i >= 2, 16'h00c8, (i >= 2) ? 16'h0000 : 16'h00c8, 8'h00);
      end
      access(8'h05, 16'h0500, 1'b1, 16'h00c8, 16'h0000, `EXC_ILL_FUNC);
      access(`FC_WR_SINGLE, 16'h0500, 1'b0, 16'h0000, 16'h0000, `EXC_ILL_FUNC);
      $display("special words and codes test done");
      wr(16'h02ff, 16'h0000, `EXC_NONE);
      access(`FC_RD_HOLD, 16'h0300, 1'b0, 16'h0000, 16'h0000, `EXC_ILL_ADDR);
      wr(`ADDR_STATUS, 16'h0000, `EXC_ILL_ADDR);
      wr(`ADDR_DIAG_PAR2, 16'h0000, `EXC_ILL_ADDR);
      wr(16'd6020, 16'h0abc, `EXC_NONE);
      rd(16'd6020, 16'h0abc);
      wr(16'd6173, 16'h0100, `EXC_NONE);
      rd(16'd6173, 16'h0100);
      wr(16'd6025, 16'h0001, `EXC_ILL_ADDR);
      wr(16'd6174, 16'h0001, `EXC_ILL_ADDR);
      $display("address map test done");
      i_lbm.img_write(9'd191, 16'ha5a5);
      i_lbm.img_write(9'd192, 16'h5a5a);
      i_lbm.img_write(9'd0, 16'h0bad);
      i_lbm.img_write(9'd3, 16'h0c0d);
      rd(16'd191, 16'ha5a5);
      rd(16'd192, 16'h5a5a);
      wr(16'd191, 16'h0000, `EXC_ILL_ADDR);
      wr(16'd575, 16'h1111, `EXC_NONE);
      img(9'd191, 16'h1111);
      wr(16'd576, 16'h2222, `EXC_NONE);
      img(9'd192, 16'h2222);
      rd(`ADDR_LOCAL_DI + 16'h0001, 16'h0bad);
      rd(`ADDR_LOCAL_DI + `BUS_IN_WORDS, 16'h0c0d);
      wr(`ADDR_LOCAL_DI + 16'h0001, 16'h0000, `EXC_ILL_ADDR);
      i_lbm.set_pins(8'h5a);
      repeat (3) @(posedge core_clk);
      rd(`ADDR_LOCAL_DI, 16'h005a);
      wr(16'd8005, 16'h000f, `EXC_NONE);
      @(posedge core_clk);
      #1;
      check({12'h000, localDoPins}, 16'h000f);
      wr(16'd8006, 16'h0c0c, `EXC_NONE);
      rd(16'd384, 16'h0c0c);
      $display("process data test done");
      i_lbm.set_state(1'b0, 1'b1, 1'b1);
      rd(`ADDR_LB_DIAG, 16'h0000);
      i_lbm.set_state(1'b1, 1'b0, 1'b0);
      rd(`ADDR_LB_DIAG, 16'h0080);
      i_lbm.set_state(1'b1, 1'b1, 1'b0);
      rd(`ADDR_LB_DIAG, 16'h00c0);
      i_lbm.set_state(1'b1, 1'b1, 1'b1);
      rd(`ADDR_LB_DIAG, 16'h00e0);
      rd(`ADDR_DIAG_PAR1, 16'h0000);
      rd(`ADDR_STATUS, 16'h0001);
      $display("operating flags test done");
      for (int i = 0; i < 4; i++) begin
         dExp = (MODES[i] == 16'h0002) ? 16'h00ff : 16'h0000;
         aExp = (MODES[i] == 16'h0000) ? 16'h0000 : `ANALOG_DEFAULT;
         aExp = (MODES[i] == 16'h0002) ? 16'h2222 : aExp;
         wr(`ADDR_FAULT_MODE, MODES[i], `EXC_NONE);
         wr(16'd386, 16'h00ff, `EXC_NONE);
         i_lbm.pulse(1'b1, 4'h0, 1'b0, 16'h0000);
         rd(`ADDR_LB_DIAG, 16'h00f0);
         rd(`ADDR_STATUS, 16'h0000);
         img(9'd2, dExp);
         img(9'd192, aExp);
         i_lbm.pulse(1'b0, 4'h1 << i, 1'b0, 16'h0100 + 16'(i));
         rd(`ADDR_LB_DIAG, 16'h00e0 | (16'h0001 << i));
         rd(`ADDR_DIAG_PAR1, 16'h0100 + 16'(i));
         rd(`ADDR_DIAG_PAR2, ~(16'h0100 + 16'(i)));
         check({15'h0000, localBusStop}, {15'h0000, i >= 2});
         rd(`ADDR_LB_DIAG, 16'h00e0 | (16'h0001 << i));
         i_lbm.pulse(1'b0, 4'h0, 1'b1, 16'h0000);
         rd(`ADDR_LB_DIAG, 16'h00e0);
         rd(`ADDR_DIAG_PAR1, 16'h0000);
         check({15'h0000, localBusStop}, 16'h0000);
      end
      $display("error flags test done");
      i_lbm.set_net(1'b1, 16'h0007);
      rd(`ADDR_STATUS, 16'h0002);
      rd(`ADDR_FAIL_REASON, 16'h0007);
      check({15'h0000, ackSeen}, 16'h0000);
      wr(`ADDR_COMMAND, `CMD_NETFAIL_ACK, `EXC_NONE);
      check({15'h0000, ackSeen}, 16'h0001);
      i_lbm.set_net(1'b0, 16'h0000);
      rd(`ADDR_FAIL_REASON, 16'h0000);
      rd(`ADDR_STATUS, 16'h0001);
      $display("link loss test done");
      stop_test();
   end
endmodule
